/* File: rtl/cis_pkg.sv */
package cis_pkg;
    localparam int          CIS_NUM_CHAN     = 16;
    localparam int          CIS_ADDR_W       = 11;
    localparam int          CIS_DATA_W       = 8;
    // Offset of the low summary register is not given; chosen value
    localparam logic [10:0] CIS_OFS_SUM_LO   = 11'h200;
    localparam logic [10:0] CIS_OFS_SUM_HI   = 11'h300;
    localparam logic [10:0] CIS_OFS_SUM_CH0  = 11'h380;
    localparam logic [10:0] CIS_OFS_TIMER    = 11'h3C0;
    localparam logic [10:0] CIS_OFS_IRQ_STAT = 11'h3C4;
    localparam logic [10:0] CIS_OFS_IRQ_MASK = 11'h3C8;
    localparam int          CIS_HI_FIRST_CH  = 9;
    localparam int          CIS_HI_BITS      = 7;
    localparam int          CIS_CH0_BIT      = 7;
    localparam int          CIS_TMR_BIT      = 0;
    localparam int          CIS_IRQ_CHAN_BIT = 0;
    localparam int          CIS_IRQ_TMR_BIT  = 1;
    localparam logic [7:0]  CIS_RST_TIMER    = 8'h00;
    localparam logic [7:0]  CIS_RST_IRQ_STAT = 8'h00;
    localparam logic [7:0]  CIS_RST_IRQ_MASK = 8'h00;

    typedef struct packed {
        logic [10:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } cis_req_type;
endpackage : cis_pkg

/* File: rtl/cis_w1c_bit.sv */
`timescale 1ns/1ps
module cis_w1c_bit (
    input  wire logic clk_in,    // Clock
    input  wire logic srst_in,   // Sync reset
    input  wire logic ce_in,     // Clock enable
    input  wire logic set_in,    // Event pulse
    input  wire logic clr_in,    // Write-one clear
    output logic      flag_out   // Sticky flag
);
    logic flag_d;

    // Set wins over a clear in the same cycle so no event is lost
    assign flag_d = set_in | (flag_out & ~clr_in);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            flag_out <= 1'b0;
        end else if (ce_in) begin
            flag_out <= flag_d;
        end
    end
endmodule : cis_w1c_bit

/* File: rtl/cis_top.sv */
// Summary of operation
// - Summary bit high while channel interrupt pending
// - Low register: channels 8..1 on bits 7..0
// - 0x300: channels 15..9 on bits 6..0
// - 0x380: channel 0 on bit 7
// - 0x3C0 bit 0 set on timer expiry
// - Writing one clears expiry flag, zero ignored
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module cis_top (
    input  wire logic                 clk_in,       // 100 MHz clock
    input  wire logic                 srst_in,      // Sync reset, active high
    input  wire logic                 ce_in,        // Clock enable
    input  wire cis_pkg::cis_req_type req_in,       // Register request
    input  wire logic [15:0]          chan_irq_in,  // Per-channel pending OR, same clock
    input  wire logic                 timer_exp_in, // One-second expiry pulse
    output logic [7:0]                rdata_out,    // Read data, cycle after read
    output logic                      irq_out       // Level interrupt
);
    import cis_pkg::*;

    logic [15:0] chan_pend_q;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;
    logic [7:0]  irq_mask_q;
    logic        second_expiry_flag;
    logic        chan_evt_flag;
    logic [7:0]  irq_stat;

    wire         hit_lo   = (req_in.addr == CIS_OFS_SUM_LO);
    wire         hit_hi   = (req_in.addr == CIS_OFS_SUM_HI);
    wire         hit_ch0  = (req_in.addr == CIS_OFS_SUM_CH0);
    wire         hit_tmr  = (req_in.addr == CIS_OFS_TIMER);
    wire         hit_stat = (req_in.addr == CIS_OFS_IRQ_STAT);
    wire         hit_mask = (req_in.addr == CIS_OFS_IRQ_MASK);

    // Summary registers ignore writes entirely
    wire         wr_tmr   = req_in.wr & hit_tmr;
    wire         wr_stat  = req_in.wr & hit_stat;
    wire         wr_mask  = req_in.wr & hit_mask;

    wire [7:0]   chan_pending_1_to_8  = chan_pend_q[8:1];
    wire [6:0]   chan_pending_9_to_15 = chan_pend_q[15:CIS_HI_FIRST_CH];
    wire         chan_pending_zero    = chan_pend_q[0];

    wire [7:0]   channel_irq_summary_lo  = chan_pending_1_to_8;
    wire [7:0]   channel_irq_summary_hi  = {1'b0, chan_pending_9_to_15};
    wire [7:0]   channel_irq_summary_ch0 = {chan_pending_zero, 7'h00};
    wire [7:0]   second_timer_irq_status = {7'h00, second_expiry_flag};

    // New pending on any channel raises the channel event bit
    wire         chan_rise = |(chan_irq_in & ~chan_pend_q);

    assign irq_stat = {6'h00, second_expiry_flag, chan_evt_flag};

    // Registered copy keeps reads stable against same-cycle source change
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            chan_pend_q <= 16'h0000;
        end else if (ce_in) begin
            chan_pend_q <= chan_irq_in;
        end
    end

    // Timer flag also clears from the interrupt status register
    cis_w1c_bit u_tmr_flag (
        .clk_in   (clk_in),
        .srst_in  (srst_in),
        .ce_in    (ce_in),
        .set_in   (timer_exp_in),
        .clr_in   ((wr_tmr & req_in.wdata[CIS_TMR_BIT]) |
                   (wr_stat & req_in.wdata[CIS_IRQ_TMR_BIT])),
        .flag_out (second_expiry_flag)
    );

    cis_w1c_bit u_chan_flag (
        .clk_in   (clk_in),
        .srst_in  (srst_in),
        .ce_in    (ce_in),
        .set_in   (chan_rise),
        .clr_in   (wr_stat & req_in.wdata[CIS_IRQ_CHAN_BIT]),
        .flag_out (chan_evt_flag)
    );

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            irq_mask_q <= CIS_RST_IRQ_MASK;
        end else if (ce_in && wr_mask) begin
            irq_mask_q <= {6'h00, req_in.wdata[1:0]};
        end
    end

    assign irq_out = |(irq_stat & irq_mask_q);

    always_comb begin
        rdata_d = 8'h00;
        if (req_in.rd) begin
            if (hit_lo) begin
                rdata_d = channel_irq_summary_lo;
            end else if (hit_hi) begin
                rdata_d = channel_irq_summary_hi;
            end else if (hit_ch0) begin
                rdata_d = channel_irq_summary_ch0;
            end else if (hit_tmr) begin
                rdata_d = second_timer_irq_status;
            end else if (hit_stat) begin
                rdata_d = irq_stat;
            end else if (hit_mask) begin
                rdata_d = irq_mask_q;
            end
        end
    end

    // Unmapped reads return zero
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_q <= 8'h00;
        end else if (ce_in) begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_out = rdata_q;
endmodule : cis_top

/* File: test/cis_top_props.sv */
`timescale 1ns/1ps
module cis_top_props (
    input  wire logic                 clk_in,       // Clock
    input  wire logic                 srst_in,      // Reset
    input  wire logic                 ce_in,        // Enable
    input  wire cis_pkg::cis_req_type req_in,       // Request
    input  wire logic [15:0]          chan_irq_in,  // Pending
    input  wire logic                 timer_exp_in, // Expiry
    input  wire logic [7:0]           rdata_out,    // Read data
    input  wire logic                 irq_out       // Interrupt
);
    import cis_pkg::*;
    logic        ok_q;
    wire         rd = ce_in && req_in.rd && !srst_in;
    wire         wr = ce_in && req_in.wr && !srst_in;
    wire  [10:0] a  = req_in.addr;
    // Summary copy lags one cycle, so reads see inputs from two edges back
    always_ff @(posedge clk_in) ok_q <= ce_in && !srst_in;
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    chk_lo_map: assert property ($past(rd && a == CIS_OFS_SUM_LO) && $past(ok_q) |->
        rdata_out == $past(chan_irq_in[8:1], 2)) else $error("low summary wrong");
    chk_hi_map: assert property ($past(rd && a == CIS_OFS_SUM_HI) && $past(ok_q) |->
        rdata_out == {1'b0, $past(chan_irq_in[15:9], 2)}) else $error("high summary wrong");
    chk_ch0_map: assert property ($past(rd && a == CIS_OFS_SUM_CH0) && $past(ok_q) |->
        rdata_out == {$past(chan_irq_in[0], 2), 7'h00}) else $error("channel zero wrong");
    chk_tmr_set: assert property (ce_in && timer_exp_in ##1 rd && a == CIS_OFS_TIMER |=>
        rdata_out == 8'h01) else $error("expiry flag not set");
    chk_tmr_clr: assert property (wr && a == CIS_OFS_TIMER && req_in.wdata[0] &&
        !timer_exp_in ##1 rd && a == CIS_OFS_TIMER |=> rdata_out == 8'h00)
        else $error("expiry flag not cleared");
    chk_tmr_rsvd: assert property ($past(rd && a == CIS_OFS_TIMER) |->
        rdata_out[7:1] == 7'h00) else $error("reserved bits set");
    chk_rst_zero: assert property ($fell(srst_in) |-> rdata_out == 8'h00 && !irq_out)
        else $error("outputs not cleared by reset");
    cover property (rd && a == CIS_OFS_SUM_HI);
    cover property (wr && a == CIS_OFS_TIMER && req_in.wdata[0]);
    cover property (irq_out);
endmodule : cis_top_props
bind cis_top cis_top_props u_props (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in),
    .req_in(req_in), .chan_irq_in(chan_irq_in), .timer_exp_in(timer_exp_in),
    .rdata_out(rdata_out), .irq_out(irq_out));

/* File: test/tb_cis_top.sv */
`timescale 1ns/1ps
module tb_cis_top;
    import cis_pkg::*;
    logic        clk_in, srst_in, ce_in, timer_exp_in, irq_out;
    cis_req_type r;
    logic [15:0] chan_irq_in;
    logic [7:0]  rdata_out;
    logic [31:0] s = 32'h00018697;
    int          miscompares = 0, num_checks = 0;
    logic [10:0] am [4] = '{CIS_OFS_SUM_LO, CIS_OFS_SUM_HI, CIS_OFS_SUM_CH0, 11'h100};
    cis_top dut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in), .req_in(r),
        .chan_irq_in(chan_irq_in), .timer_exp_in(timer_exp_in), .rdata_out(rdata_out),
        .irq_out(irq_out));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    function automatic logic [15:0] xs();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s[15:0];
    endfunction : xs
    function automatic logic [7:0] exp_sum(input logic [10:0] a, input logic [15:0] c);
        return a == CIS_OFS_SUM_LO ? c[8:1] : a == CIS_OFS_SUM_HI ? {1'b0, c[15:9]} :
            a == CIS_OFS_SUM_CH0 ? {c[0], 7'h00} : 8'h00;
    endfunction : exp_sum
    task automatic chk(input logic [7:0] v, input logic [7:0] e);
        num_checks++;
        if (v !== e) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, v, e);
        end
    endtask : chk
    // Write strobe stands for exactly one cycle, then the bus goes idle
    task automatic wrc(input logic [10:0] a, input logic [7:0] d);
        @(posedge clk_in) r <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_in) r <= '0;
    endtask : wrc
    task automatic rdc(input logic [10:0] a, input logic [7:0] e);
        @(posedge clk_in) r <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_in) r <= '0;
        #1 chk(rdata_out, e);
    endtask : rdc
    task test_done;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done
    initial begin
        srst_in = 1'b1;
        ce_in = 1'b1;
        timer_exp_in = 1'b0;
        r = '0;
        chan_irq_in = 16'h0000;
        repeat (20) @(posedge clk_in);
        srst_in <= 1'b0;
        rdc(CIS_OFS_TIMER, 8'h00);
        for (int i = 0; i < 20; i++) begin
            @(posedge clk_in) chan_irq_in <= i == 0 ? 16'hFFFF : i == 1 ? 16'h8001 : xs();
            wrc(am[i % 3], 8'hFF);
            for (int k = 0; k < 4; k++) rdc(am[k], exp_sum(am[k], chan_irq_in));
        end
        chk({7'h00, irq_out}, 8'h00);
        wrc(CIS_OFS_IRQ_MASK, 8'h03);
        rdc(CIS_OFS_IRQ_STAT, 8'h01);
        chk({7'h00, irq_out}, 8'h01);
        wrc(CIS_OFS_IRQ_STAT, 8'h01);
        rdc(CIS_OFS_IRQ_STAT, 8'h00);
        chk({7'h00, irq_out}, 8'h00);
        @(posedge clk_in) timer_exp_in <= 1'b1;
        @(posedge clk_in) timer_exp_in <= 1'b0;
        rdc(CIS_OFS_TIMER, 8'h01);
        chk({7'h00, irq_out}, 8'h01);
        wrc(CIS_OFS_TIMER, 8'hFE);
        rdc(CIS_OFS_TIMER, 8'h01);
        wrc(CIS_OFS_TIMER, 8'h01);
        rdc(CIS_OFS_TIMER, 8'h00);
        chk({7'h00, irq_out}, 8'h00);
        // Expiry while frozen must be lost, since the enable stops every flop
        @(posedge clk_in) begin
            ce_in <= 1'b0;
            timer_exp_in <= 1'b1;
        end
        @(posedge clk_in) begin
            ce_in <= 1'b1;
            timer_exp_in <= 1'b0;
        end
        rdc(CIS_OFS_TIMER, 8'h00);
        // Mid-run reset with the flag and mask set
        @(posedge clk_in) timer_exp_in <= 1'b1;
        @(posedge clk_in) timer_exp_in <= 1'b0;
        @(posedge clk_in) srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        rdc(CIS_OFS_TIMER, 8'h00);
        rdc(CIS_OFS_IRQ_MASK, 8'h00);
        chk({7'h00, irq_out}, 8'h00);
        test_done();
    end
endmodule : tb_cis_top
